//--- rtl/hps_defines.svh
// Offsets, field positions, reset values and bus response codes for the pin mux
`ifndef HPS_DEFINES_SVH
`define HPS_DEFINES_SVH

`define HPS_ADDR_W 5
`define HPS_REG_PA_SEL 5'h00
`define HPS_REG_PB_SEL 5'h04
`define HPS_REG_PE_SEL 5'h08
`define HPS_REG_SER_SEL 5'h0C
`define HPS_REG_MISC 5'h10
`define HPS_REG_STATUS 5'h14

`define HPS_PA_SEL_RST 2'h0
`define HPS_PB_SEL_RST 10'h000
`define HPS_PE_SEL_RST 5'h00
`define HPS_SER_SEL_RST 2'h0
`define HPS_MISC_RST 4'h0

`define HPS_MISC_STAT_GP 0
`define HPS_MISC_STAT_VAL 1
`define HPS_MISC_RES_OUT 2
`define HPS_MISC_RUN 3

`define HPS_BOOT_ADDR 16'h0000
`define HPS_RESP_OKAY 2'h0
`define HPS_RESP_SLVERR 2'h2

`endif

//--- rtl/hps_pkg.sv
// Types for the header pin function select block
package hps_pkg;
  typedef enum logic [1:0] {
    HPS_PA_PARALLEL,
    HPS_PA_EXT_IO,
    HPS_PA_SLAVE
  } hps_pa_mode_e;

  typedef enum logic [1:0] {
    HPS_BOOT_EXEC,
    HPS_BOOT_COLD
  } hps_boot_e;

  typedef enum logic [1:0] {
    HPS_BUS_IDLE,
    HPS_BUS_RESP
  } hps_bus_state_e;
endpackage : hps_pkg

//--- rtl/hps_pin_cell.sv
// One header pin with up to three drivers and owned output enable
`timescale 1ns/1ps
module hps_pin_cell (
  input wire logic [1:0] sel_i,
  input wire logic gpio_out_i,
  input wire logic gpio_oe_i,
  input wire logic alt1_out_i,
  input wire logic alt1_oe_i,
  input wire logic alt2_out_i,
  input wire logic alt2_oe_i,
  input wire logic pin_in_i,
  output logic pin_out_o,
  output logic pin_oe_o,
  output logic gpio_in_o,
  output logic alt1_in_o,
  output logic alt2_in_o
);
  always_comb begin
    pin_out_o = 1'b0;
    pin_oe_o = 1'b0;
    gpio_in_o = 1'b0;
    alt1_in_o = 1'b0;
    alt2_in_o = 1'b0;
    case (sel_i)
      2'h1: begin
        pin_out_o = alt1_out_i;
        pin_oe_o = alt1_oe_i;
        alt1_in_o = pin_in_i;
      end
      2'h2: begin
        pin_out_o = alt2_out_i;
        pin_oe_o = alt2_oe_i;
        alt2_in_o = pin_in_i;
      end
      default: begin
        pin_out_o = gpio_out_i;
        pin_oe_o = gpio_oe_i;
        gpio_in_o = pin_in_i;
      end
    endcase
  end
endmodule : hps_pin_cell

//--- rtl/hps_pin_mux.sv
// Header pin function select with AXI4-Lite configuration registers
// Function
// - Pins reset to default role; software selects listed alternates.
// - Port A: parallel I/O, external I/O data bus, or slave data.
// - External I/O bus keeps I/O traffic off the main data bus.
// - Port B bits 2-5,7 carry auxiliary address bits 0,1,2,3,5.
// - Port B bit 2 alternate: active-low slave write strobe.
// - Port B bit 3 alternate: active-low slave read strobe.
// - Port B bits 4,5 alternate: slave register address bits 0,1.
// - Port B bit 7 alternate: active-low slave attention output.
// - Port E bit 7: I/O strobe 7 or active-low slave chip select.
// - Serial port F shares C/D receive pins, disabling those receives.
// - Port D bits 4,5: alternate serial port B transmit/receive.
// - Dedicated active-low I/O write and read strobes reach the header.
// - Status pin usable as general output once program runs.
// - Reset pin drives reset generator output; outside may also drive.
// - Startup pins choose cold boot or execution from address zero.
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "hps_defines.svh"
module hps_pin_mux
  import hps_pkg::*;
#(
  parameter int NPB = 5,
  parameter int NPE = 5
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // AXI4-Lite slave
  input wire logic [`HPS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`HPS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core side functions
  input wire logic [7:0] gpio_a_out_i,
  input wire logic [7:0] gpio_a_oe_i,
  output logic [7:0] gpio_a_in_o,
  input wire logic [7:0] ext_io_data_out_i,
  input wire logic ext_io_data_oe_i,
  output logic [7:0] ext_io_data_in_o,
  input wire logic [7:0] slave_data_out_i,
  input wire logic slave_data_oe_i,
  output logic [7:0] slave_data_in_o,
  input wire logic [7:0] main_data_out_i,
  input wire logic main_data_oe_i,
  output logic [7:0] main_data_bus_o,
  output logic main_data_bus_oe_o,
  input wire logic io_cycle_i,
  input wire logic io_write_i,
  input wire logic io_read_i,
  input wire logic [NPB-1:0] gpio_b_out_i,
  input wire logic [NPB-1:0] gpio_b_oe_i,
  output logic [NPB-1:0] gpio_b_in_o,
  input wire logic [5:0] aux_addr_i,
  input wire logic slave_attn_i,
  output logic slave_write_strobe_n_o,
  output logic slave_read_strobe_n_o,
  output logic [1:0] slave_reg_addr_o,
  input wire logic [NPE-1:0] gpio_e_out_i,
  input wire logic [NPE-1:0] gpio_e_oe_i,
  output logic [NPE-1:0] gpio_e_in_o,
  input wire logic [NPE-1:0] io_strobe_n_i,
  output logic [3:0] ext_irq_o,
  output logic slave_chip_select_n_o,
  input wire logic hdlc_port_f_transmit_i,
  output logic hdlc_port_f_receive_o,
  output logic port_c_receive_o,
  output logic port_d_receive_o,
  input wire logic port_d_transmit_i,
  input wire logic port_c_transmit_i,
  input wire logic [1:0] gpio_d_out_i,
  input wire logic [1:0] gpio_d_oe_i,
  output logic [1:0] gpio_d_in_o,
  input wire logic alt_port_b_transmit_i,
  output logic alt_port_b_receive_o,
  input wire logic status_fn_i,
  input wire logic reset_gen_n_i,
  output logic core_reset_n_o,
  output logic boot_cold_o,
  output logic [15:0] boot_addr_o,
  // Header pins
  input wire logic [7:0] pa_pin_i,
  output logic [7:0] pa_pin_o,
  output logic [7:0] pa_pin_oe_o,
  input wire logic [NPB-1:0] pb_pin_i,
  output logic [NPB-1:0] pb_pin_o,
  output logic [NPB-1:0] pb_pin_oe_o,
  input wire logic [NPE-1:0] pe_pin_i,
  output logic [NPE-1:0] pe_pin_o,
  output logic [NPE-1:0] pe_pin_oe_o,
  input wire logic [1:0] pc_rx_pin_i,
  output logic [1:0] pc_rx_pin_o,
  output logic [1:0] pc_rx_pin_oe_o,
  output logic [1:0] pc_tx_pin_o,
  input wire logic [1:0] pd_pin_i,
  output logic [1:0] pd_pin_o,
  output logic [1:0] pd_pin_oe_o,
  output logic io_write_strobe_n_o,
  output logic io_read_strobe_n_o,
  output logic status_pin_o,
  input wire logic module_reset_n_i,
  output logic module_reset_n_o,
  output logic module_reset_n_oe_o,
  input wire logic startup_select_0_i,
  input wire logic startup_select_1_i
);
  typedef struct packed {
    hps_bus_state_e wst;
    hps_bus_state_e rst;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] pa_sel;
    logic [2*NPB-1:0] pb_sel;
    logic [NPE-1:0] pe_sel;
    logic [NPE-1:0] pe_strb;
    logic [1:0] ser_sel;
    logic [3:0] misc;
    logic [7:0] pa_o;
    logic [7:0] pa_oe;
    logic [NPB-1:0] pb_o;
    logic [NPB-1:0] pb_oe;
    logic [NPE-1:0] pe_o;
    logic [NPE-1:0] pe_oe;
    logic [1:0] pcr_o;
    logic [1:0] pcr_oe;
    logic [1:0] pct_o;
    logic [1:0] pd_o;
    logic [1:0] pd_oe;
    logic io_write_strobe_n_n;
    logic io_read_strobe_n_n;
    logic stat;
    logic res_o;
    logic res_oe;
    logic core_rst_n;
    logic boot_cold;
    logic boot_seen;
    logic [7:0] md;
    logic md_oe;
  } hps_state_s;

  hps_state_s q, d;

  // Alternate-function wiring: sel 0 gpio, 1 first alternate, 2 second
  logic [NPB-1:0] pb_a1_o, pb_a1_oe, pb_a2_o, pb_a2_oe, pb_a2_in;
  logic [NPB-1:0] pb_po, pb_poe;
  logic [NPE-1:0] pe_a2_in, pe_po, pe_poe;
  logic [7:0] pa_ext_in, pa_sl_in, pa_po, pa_poe;

  // Port B pins are 2,3,4,5,7: aux address bits 0,1,2,3,5
  always_comb begin
    pb_a1_o = {aux_addr_i[5], aux_addr_i[3:0]};
    pb_a1_oe = '1;
    pb_a2_o = {slave_attn_i, 4'h0};
    pb_a2_oe = {1'b1, 4'h0};
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pa
      hps_pin_cell u_cell (
        .sel_i(q.pa_sel),
        .gpio_out_i(gpio_a_out_i[g]),
        .gpio_oe_i(gpio_a_oe_i[g]),
        .alt1_out_i(ext_io_data_out_i[g]),
        .alt1_oe_i(ext_io_data_oe_i),
        .alt2_out_i(slave_data_out_i[g]),
        .alt2_oe_i(slave_data_oe_i),
        .pin_in_i(pa_pin_i[g]),
        .pin_out_o(pa_po[g]),
        .pin_oe_o(pa_poe[g]),
        .gpio_in_o(gpio_a_in_o[g]),
        .alt1_in_o(pa_ext_in[g]),
        .alt2_in_o(pa_sl_in[g])
      );
    end
    for (g = 0; g < NPB; g++) begin : g_pb
      hps_pin_cell u_cell (
        .sel_i(q.pb_sel[2*g+:2]),
        .gpio_out_i(gpio_b_out_i[g]),
        .gpio_oe_i(gpio_b_oe_i[g]),
        .alt1_out_i(pb_a1_o[g]),
        .alt1_oe_i(pb_a1_oe[g]),
        .alt2_out_i(pb_a2_o[g]),
        .alt2_oe_i(pb_a2_oe[g]),
        .pin_in_i(pb_pin_i[g]),
        .pin_out_o(pb_po[g]),
        .pin_oe_o(pb_poe[g]),
        .gpio_in_o(gpio_b_in_o[g]),
        .alt1_in_o(),
        .alt2_in_o(pb_a2_in[g])
      );
    end
    for (g = 0; g < NPE; g++) begin : g_pe
      hps_pin_cell u_cell (
        .sel_i({q.pe_sel[g], q.pe_strb[g] && !q.pe_sel[g]}),
        .gpio_out_i(gpio_e_out_i[g]),
        .gpio_oe_i(gpio_e_oe_i[g]),
        .alt1_out_i(io_strobe_n_i[g]),
        .alt1_oe_i(1'b1),
        .alt2_out_i(1'b0),
        .alt2_oe_i(1'b0),
        .pin_in_i(pe_pin_i[g]),
        .pin_out_o(pe_po[g]),
        .pin_oe_o(pe_poe[g]),
        .gpio_in_o(gpio_e_in_o[g]),
        .alt1_in_o(),
        .alt2_in_o(pe_a2_in[g])
      );
    end
  endgenerate

  logic aw_ok, w_ok, ar_ok;
  always_comb begin
    aw_ok = s_axi_awvalid && s_axi_wvalid && q.wst == HPS_BUS_IDLE && ce_i;
    ar_ok = s_axi_arvalid && q.rst == HPS_BUS_IDLE && ce_i;
    w_ok = aw_ok;
  end

  always_comb begin
    d = q;
    // Bus writes
    if (aw_ok) begin
      d.wst = HPS_BUS_RESP;
      d.bresp = `HPS_RESP_OKAY;
      case (s_axi_awaddr)
        `HPS_REG_PA_SEL: if (s_axi_wstrb[0]) d.pa_sel = s_axi_wdata[1:0];
        `HPS_REG_PB_SEL: begin
          if (s_axi_wstrb[0]) d.pb_sel[7:0] = s_axi_wdata[7:0];
          if (s_axi_wstrb[1]) d.pb_sel[2*NPB-1:8] = s_axi_wdata[2*NPB-1:8];
        end
        `HPS_REG_PE_SEL: begin
          if (s_axi_wstrb[0]) d.pe_sel = s_axi_wdata[NPE-1:0];
          if (s_axi_wstrb[1]) d.pe_strb = s_axi_wdata[8+:NPE];
        end
        `HPS_REG_SER_SEL: if (s_axi_wstrb[0]) d.ser_sel = s_axi_wdata[1:0];
        `HPS_REG_MISC: if (s_axi_wstrb[0]) d.misc = s_axi_wdata[3:0];
        `HPS_REG_STATUS: ;
        default: d.bresp = `HPS_RESP_SLVERR;
      endcase
    end else if (q.wst == HPS_BUS_RESP && s_axi_bready) begin
      d.wst = HPS_BUS_IDLE;
    end
    // Bus reads
    if (ar_ok) begin
      d.rst = HPS_BUS_RESP;
      d.rresp = `HPS_RESP_OKAY;
      case (s_axi_araddr)
        `HPS_REG_PA_SEL: d.rdata = {30'h0, q.pa_sel};
        `HPS_REG_PB_SEL: d.rdata = 32'({q.pb_sel});
        `HPS_REG_PE_SEL: d.rdata = 32'(q.pe_sel) | (32'(q.pe_strb) << 8);
        `HPS_REG_SER_SEL: d.rdata = {30'h0, q.ser_sel};
        `HPS_REG_MISC: d.rdata = {28'h0, q.misc};
        `HPS_REG_STATUS: d.rdata = {28'h0, module_reset_n_i, q.boot_cold,
                                    startup_select_1_i, startup_select_0_i};
        default: begin
          d.rdata = 32'h0000_0000;
          d.rresp = `HPS_RESP_SLVERR;
        end
      endcase
    end else if (q.rst == HPS_BUS_RESP && s_axi_rready) begin
      d.rst = HPS_BUS_IDLE;
    end
    // Pin drivers registered so every pin output comes from a flip-flop
    d.pa_o = pa_po;
    d.pa_oe = pa_poe;
    d.pb_o = pb_po;
    d.pb_oe = pb_poe;
    d.pe_o = pe_po;
    d.pe_oe = pe_poe;
    // Main data bus sees I/O cycles only when port A is not the I/O bus
    d.md = main_data_out_i;
    d.md_oe = main_data_oe_i &&
              !(io_cycle_i && q.pa_sel == 2'(HPS_PA_EXT_IO));
    // Serial F on receive pins: C/D receives given up
    d.pcr_o = q.ser_sel[0] ? {1'b0, hdlc_port_f_transmit_i} : 2'h0;
    d.pcr_oe = q.ser_sel[0] ? 2'h1 : 2'h0;
    d.pct_o = {port_c_transmit_i, port_d_transmit_i};
    d.pd_o = q.ser_sel[1] ? {1'b0, alt_port_b_transmit_i} : gpio_d_out_i;
    d.pd_oe = q.ser_sel[1] ? 2'h1 : gpio_d_oe_i;
    d.io_write_strobe_n_n = !(io_cycle_i && io_write_i);
    d.io_read_strobe_n_n = !(io_cycle_i && io_read_i);
    d.stat = (q.misc[`HPS_MISC_RUN] && q.misc[`HPS_MISC_STAT_GP]) ?
             q.misc[`HPS_MISC_STAT_VAL] : status_fn_i;
    d.res_o = 1'b0;
    d.res_oe = !reset_gen_n_i || q.misc[`HPS_MISC_RES_OUT];
    d.core_rst_n = module_reset_n_i;
    if (!q.boot_seen) begin
      d.boot_seen = 1'b1;
      d.boot_cold = startup_select_0_i && startup_select_1_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      q <= '0;
      q.pa_sel <= `HPS_PA_SEL_RST;
      q.pb_sel <= `HPS_PB_SEL_RST;
      q.pe_sel <= `HPS_PE_SEL_RST;
      q.ser_sel <= `HPS_SER_SEL_RST;
      q.misc <= `HPS_MISC_RST;
      q.io_write_strobe_n_n <= 1'b1;
      q.io_read_strobe_n_n <= 1'b1;
      q.core_rst_n <= 1'b1;
    end else if (ce_i) begin
      q <= d;
    end
  end

  always_comb begin
    s_axi_awready = aw_ok;
    s_axi_wready = w_ok;
    s_axi_bvalid = q.wst == HPS_BUS_RESP;
    s_axi_bresp = q.bresp;
    s_axi_arready = ar_ok;
    s_axi_rvalid = q.rst == HPS_BUS_RESP;
    s_axi_rdata = q.rdata;
    s_axi_rresp = q.rresp;
    pa_pin_o = q.pa_o;
    pa_pin_oe_o = q.pa_oe;
    pb_pin_o = q.pb_o;
    pb_pin_oe_o = q.pb_oe;
    pe_pin_o = q.pe_o;
    pe_pin_oe_o = q.pe_oe;
    pc_rx_pin_o = q.pcr_o;
    pc_rx_pin_oe_o = q.pcr_oe;
    pc_tx_pin_o = q.pct_o;
    pd_pin_o = q.pd_o;
    pd_pin_oe_o = q.pd_oe;
    io_write_strobe_n_o = q.io_write_strobe_n_n;
    io_read_strobe_n_o = q.io_read_strobe_n_n;
    status_pin_o = q.stat;
    module_reset_n_o = q.res_o;
    module_reset_n_oe_o = q.res_oe;
    core_reset_n_o = q.core_rst_n;
    boot_cold_o = q.boot_cold;
    boot_addr_o = `HPS_BOOT_ADDR;
    main_data_bus_o = q.md;
    main_data_bus_oe_o = q.md_oe;
    ext_io_data_in_o = pa_ext_in;
    slave_data_in_o = pa_sl_in;
    slave_write_strobe_n_o = pb_a2_in[0] | (q.pb_sel[1:0] != 2'h2);
    slave_read_strobe_n_o = pb_a2_in[1] | (q.pb_sel[3:2] != 2'h2);
    slave_reg_addr_o = pb_a2_in[3:2];
    ext_irq_o = {pe_a2_in[3], pe_a2_in[2], pe_a2_in[1], pe_a2_in[0]};
    slave_chip_select_n_o = !(q.pe_sel[4] && !pe_a2_in[4]) ? 1'b1 : 1'b0;
    port_d_receive_o = q.ser_sel[0] ? 1'b1 : pc_rx_pin_i[0];
    port_c_receive_o = q.ser_sel[0] ? 1'b1 : pc_rx_pin_i[1];
    hdlc_port_f_receive_o = q.ser_sel[0] ? pc_rx_pin_i[1] : 1'b1;
    alt_port_b_receive_o = q.ser_sel[1] ? pd_pin_i[1] : 1'b1;
    gpio_d_in_o = q.ser_sel[1] ? 2'h0 : pd_pin_i;
  end
endmodule : hps_pin_mux

//--- sim/hps_pin_mux_props.sv
// Port-level assertions for the header pin function select
`timescale 1ns/1ps
module hps_pin_mux_props (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic io_cycle_i,
  input wire logic io_write_i,
  input wire logic io_read_i,
  input wire logic io_write_strobe_n_o,
  input wire logic io_read_strobe_n_o,
  input wire logic main_data_oe_i,
  input wire logic main_data_bus_oe_o,
  input wire logic module_reset_n_i,
  input wire logic module_reset_n_o,
  input wire logic module_reset_n_oe_o,
  input wire logic reset_gen_n_i,
  input wire logic core_reset_n_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_bwait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  property p_wresp;
    s_wtake |=> s_axi_bvalid;
  endproperty
  a_wresp: assert property (p_wresp) else $error("no wr resp");
  property p_bhold;
    s_bwait |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid drop");
  property p_io_write_strobe_n;
    io_cycle_i && io_write_i |=> !io_write_strobe_n_o;
  endproperty
  a_io_write_strobe_n: assert property (p_io_write_strobe_n) else $error("no wr strobe");
  property p_io_read_strobe_n;
    io_cycle_i && io_read_i |=> !io_read_strobe_n_o;
  endproperty
  a_io_read_strobe_n: assert property (p_io_read_strobe_n) else $error("no rd strobe");
  property p_mainoe;
    !main_data_oe_i |=> !main_data_bus_oe_o;
  endproperty
  a_mainoe: assert property (p_mainoe) else $error("main oe");
  property p_resdrv;
    module_reset_n_oe_o |-> !module_reset_n_o;
  endproperty
  a_resdrv: assert property (p_resdrv) else $error("reset drive");
  property p_corerst;
    !module_reset_n_i |=> !core_reset_n_o;
  endproperty
  a_corerst: assert property (p_corerst) else $error("core reset");
  property p_gen;
    !reset_gen_n_i |=> module_reset_n_oe_o;
  endproperty
  a_gen: assert property (p_gen) else $error("reset out");
endmodule : hps_pin_mux_props

bind hps_pin_mux hps_pin_mux_props i_hps_pin_mux_props (.clk_i, .rstn_i,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .io_cycle_i, .io_write_i, .io_read_i, .io_write_strobe_n_o,
  .io_read_strobe_n_o, .main_data_oe_i, .main_data_bus_oe_o, .module_reset_n_i,
  .module_reset_n_o, .module_reset_n_oe_o, .reset_gen_n_i, .core_reset_n_o);

//--- sim/hps_far_pin.sv
// Far-side peripheral drive of a group of header pins
`timescale 1ns/1ps
module hps_far_pin #(
  parameter int W = 8
) (
  input wire logic [W-1:0] dev_out_i,
  input wire logic [W-1:0] dev_oe_i,
  input wire logic [W-1:0] ext_val_i,
  input wire logic [W-1:0] ext_en_i,
  output logic [W-1:0] pin_o
);
  // Device wins where it drives; board pull-ups hold idle lines high
  assign pin_o = (dev_oe_i & dev_out_i) | (~dev_oe_i & ~ext_en_i) |
                 (~dev_oe_i & ext_en_i & ext_val_i);
endmodule : hps_far_pin

//--- sim/tb_top.sv
// Self-checking bench for the header pin function select
`timescale 1ns/1ps
module tb_top;
  logic clk_i = '0, rstn_i = '0, ce_i = '1, s_axi_awvalid = '0;
  logic s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
  logic s_axi_rready = '0, ext_io_data_oe_i = '0, slave_data_oe_i = '0;
  logic main_data_oe_i = '0, io_cycle_i = '0, io_write_i = '0;
  logic io_read_i = '0, slave_attn_i = '1, hdlc_port_f_transmit_i = '0;
  logic port_d_transmit_i = '0, port_c_transmit_i = '0, status_fn_i = '0;
  logic alt_port_b_transmit_i = '0, reset_gen_n_i = '1, ext_rst_n = '1;
  logic startup_select_0_i = '1, startup_select_1_i = '1;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [4:0] s_axi_awaddr = '0, s_axi_araddr = '0, gpio_b_out_i = '0;
  logic [4:0] gpio_b_oe_i = '0, gpio_e_out_i = '0, gpio_e_oe_i = '0;
  logic [4:0] io_strobe_n_i = '1, eb = '0, eb_en = '0, ee = '0, ee_en = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [7:0] gpio_a_out_i = '0, gpio_a_oe_i = '0, ext_io_data_out_i = '0;
  logic [7:0] slave_data_out_i = '0, main_data_out_i = '0, ea = '0;
  logic [7:0] ea_en = '0;
  logic [5:0] aux_addr_i = '0;
  logic [1:0] gpio_d_out_i = '0, gpio_d_oe_i = '0, pc_rx_pin_i = '1;
  logic [1:0] pd_pin_i = '1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, main_data_bus_oe_o, slave_write_strobe_n_o;
  logic slave_read_strobe_n_o, slave_chip_select_n_o, hdlc_port_f_receive_o;
  logic port_c_receive_o, port_d_receive_o, alt_port_b_receive_o;
  logic core_reset_n_o, boot_cold_o, io_write_strobe_n_o, io_read_strobe_n_o;
  logic status_pin_o, module_reset_n_i, module_reset_n_o, module_reset_n_oe_o;
  logic [1:0] s_axi_bresp, s_axi_rresp, slave_reg_addr_o, pc_rx_pin_o;
  logic [1:0] pc_rx_pin_oe_o, pc_tx_pin_o, pd_pin_o, pd_pin_oe_o, gpio_d_in_o;
  logic [3:0] ext_irq_o;
  logic [4:0] gpio_b_in_o, gpio_e_in_o, pb_pin_i, pb_pin_o, pb_pin_oe_o;
  logic [4:0] pe_pin_i, pe_pin_o, pe_pin_oe_o;
  logic [7:0] gpio_a_in_o, ext_io_data_in_o, slave_data_in_o, main_data_bus_o;
  logic [7:0] pa_pin_i, pa_pin_o, pa_pin_oe_o;
  logic [15:0] boot_addr_o;
  int checked = 0, miscompares = 0, cycles = 0;

  hps_pin_mux i_hps_pin_mux (.*);
  hps_far_pin #(.W(8)) i_far_a (.dev_out_i(pa_pin_o), .dev_oe_i(pa_pin_oe_o),
    .ext_val_i(ea), .ext_en_i(ea_en), .pin_o(pa_pin_i));
  hps_far_pin #(.W(5)) i_far_b (.dev_out_i(pb_pin_o), .dev_oe_i(pb_pin_oe_o),
    .ext_val_i(eb), .ext_en_i(eb_en), .pin_o(pb_pin_i));
  hps_far_pin #(.W(5)) i_far_e (.dev_out_i(pe_pin_o), .dev_oe_i(pe_pin_oe_o),
    .ext_val_i(ee), .ext_en_i(ee_en), .pin_o(pe_pin_i));
  // Open-drain reset line: either side may pull it low
  assign module_reset_n_i = ext_rst_n &
                            ~(module_reset_n_oe_o & ~module_reset_n_o);

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= '1;
    s_axi_wvalid <= '1;
    s_axi_bready <= '1;
    do @(posedge clk_i); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= '0;
    s_axi_wvalid <= '0;
    do @(posedge clk_i); while (!s_axi_bvalid);
    s_axi_bready <= '0;
    chk(s_axi_bresp, r);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= '1;
    s_axi_rready <= '1;
    do @(posedge clk_i); while (!s_axi_arready);
    s_axi_arvalid <= '0;
    do @(posedge clk_i); while (!s_axi_rvalid);
    s_axi_rready <= '0;
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, r);
  endtask : rd

  initial begin
    repeat (4) @(posedge clk_i);
    rstn_i <= '1;
    for (int i = 0; i < 5; i++) rd(5'(4 * i), 32'h0, 2'h0);
    rd(5'h14, 32'hF, 2'h0);
    rd(5'h18, 32'h0, 2'h2);
    wr(5'h1C, 32'h0, 2'h2);
    chk({boot_cold_o, boot_addr_o}, 17'h10000);
    chk({io_write_strobe_n_o, slave_write_strobe_n_o}, 2'h3);
    $display("Test reset done");
    gpio_a_out_i <= 8'h5A;
    gpio_a_oe_i <= 8'hFF;
    gpio_b_out_i <= 5'h15;
    gpio_b_oe_i <= 5'h1F;
    gpio_e_out_i <= 5'h0A;
    gpio_e_oe_i <= 5'h1F;
    gpio_d_out_i <= 2'h2;
    gpio_d_oe_i <= 2'h3;
    status_fn_i <= '1;
    cyc(3);
    chk({pa_pin_oe_o, pa_pin_o, gpio_a_in_o}, 24'hFF5A5A);
    chk({pb_pin_o, pe_pin_o, pd_pin_o}, 12'hAAA);
    chk({gpio_b_in_o, gpio_e_in_o, gpio_d_in_o}, 12'hAAB);
    chk(status_pin_o, 1'b1);
    $display("Test default done");
    wr(5'h00, 32'h1, 2'h0);
    ext_io_data_out_i <= 8'hC3;
    ext_io_data_oe_i <= '1;
    cyc(3);
    chk(pa_pin_o, 8'hC3);
    ext_io_data_oe_i <= '0;
    ea <= 8'h96;
    ea_en <= 8'hFF;
    main_data_oe_i <= '1;
    main_data_out_i <= 8'h3C;
    io_cycle_i <= '1;
    io_write_i <= '1;
    cyc(3);
    chk({pa_pin_oe_o, ext_io_data_in_o, gpio_a_in_o}, 24'h009600);
    chk({main_data_bus_oe_o, io_write_strobe_n_o}, 2'h0);
    io_write_i <= '0;
    io_read_i <= '1;
    cyc(3);
    chk({io_write_strobe_n_o, io_read_strobe_n_o}, 2'h2);
    io_cycle_i <= '0;
    io_read_i <= '0;
    wr(5'h00, 32'h2, 2'h0);
    cyc(3);
    chk({main_data_bus_oe_o, slave_data_in_o}, 9'h196);
    chk(main_data_bus_o, 8'h3C);
    $display("Test port_a done");
    wr(5'h04, 32'h155, 2'h0);
    aux_addr_i <= 6'h2A;
    cyc(3);
    chk({pb_pin_oe_o, pb_pin_o}, 10'h3FA);
    wr(5'h04, 32'h2AA, 2'h0);
    eb <= 5'h0A;
    eb_en <= 5'h0F;
    slave_attn_i <= '0;
    cyc(3);
    chk({slave_write_strobe_n_o, slave_read_strobe_n_o}, 2'h1);
    chk(slave_reg_addr_o, 2'h2);
    chk({pb_pin_oe_o, pb_pin_o[4]}, 6'h20);
    $display("Test port_b done");
    wr(5'h08, 32'h1F, 2'h0);
    ee <= 5'h0B;
    ee_en <= 5'h1F;
    cyc(3);
    chk({pe_pin_oe_o, slave_chip_select_n_o, ext_irq_o}, 10'h00B);
    wr(5'h08, 32'h1F00, 2'h0);
    io_strobe_n_i <= 5'h15;
    cyc(3);
    chk({pe_pin_oe_o, pe_pin_o}, 10'h3F5);
    chk({slave_chip_select_n_o, ext_irq_o}, 5'h10);
    rd(5'h08, 32'h1F00, 2'h0);
    $display("Test port_e done");
    pc_rx_pin_i <= 2'h1;
    pd_pin_i <= 2'h1;
    cyc(2);
    chk({port_c_receive_o, port_d_receive_o}, 2'h1);
    chk(hdlc_port_f_receive_o, 1'b1);
    chk(gpio_d_in_o, 2'h1);
    wr(5'h0C, 32'h1, 2'h0);
    hdlc_port_f_transmit_i <= '1;
    port_d_transmit_i <= '1;
    cyc(3);
    chk({pc_rx_pin_oe_o[0], pc_rx_pin_o[0]}, 2'h3);
    chk(hdlc_port_f_receive_o, 1'b0);
    chk({port_c_receive_o, port_d_receive_o, pc_tx_pin_o}, 4'hD);
    wr(5'h0C, 32'h2, 2'h0);
    alt_port_b_transmit_i <= '1;
    cyc(3);
    chk({pd_pin_oe_o, pd_pin_o[0], alt_port_b_receive_o}, 4'h6);
    chk(gpio_d_in_o, 2'h0);
    chk({port_c_receive_o, port_d_receive_o}, 2'h1);
    $display("Test serial done");
    wr(5'h10, 32'hB, 2'h0);
    status_fn_i <= '0;
    cyc(3);
    chk(status_pin_o, 1'b1);
    wr(5'h10, 32'h4, 2'h0);
    cyc(3);
    chk({module_reset_n_oe_o, core_reset_n_o}, 2'h2);
    rd(5'h14, 32'h7, 2'h0);
    wr(5'h10, 32'h0, 2'h0);
    reset_gen_n_i <= '0;
    cyc(3);
    chk(module_reset_n_oe_o, 1'b1);
    reset_gen_n_i <= '1;
    ext_rst_n <= '0;
    cyc(3);
    chk({module_reset_n_oe_o, core_reset_n_o}, 2'h0);
    ext_rst_n <= '1;
    $display("Test status_reset done");
    startup_select_0_i <= '0;
    rstn_i <= '0;
    cyc(2);
    rstn_i <= '1;
    rd(5'h00, 32'h0, 2'h0);
    rd(5'h08, 32'h0, 2'h0);
    rd(5'h14, 32'hA, 2'h0);
    $display("Test rerun_reset done");
    finish_test();
  end
endmodule : tb_top
